// *** common/dcc_params.svh ***
// Purpose: Offsets, field positions, reset values of the delay config regs
// Assumes: 8-bit registers behind a two-wire serial slave
// Notes:   Included by bare name
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

// Register offsets
`define DCC_OFS_CTRL      8'h01
`define DCC_OFS_DLY_R_HI  8'h02
`define DCC_OFS_DLY_R_LO  8'h03
`define DCC_OFS_DLY_L_HI  8'h04
`define DCC_OFS_DLY_L_LO  8'h05
`define DCC_OFS_FRAME     8'h06
`define DCC_OFS_PKT_LEN   8'h07
`define DCC_OFS_COMMIT    8'h08

// Field positions
`define DCC_CTRL_MUTE_R   7
`define DCC_CTRL_MUTE_L   6
`define DCC_FRAME_EN      7
`define DCC_FRAME_RATE    6
`define DCC_COMMIT_GO     0

// Reset values
`define DCC_RST_REG       8'h00

// Limits
`define DCC_MAX_DELAY     13'h1fff
`define DCC_MAX_PKT_LEN   6'h18

// Bus address upper bits; value is arbitrary
`define DCC_BUS_ADDR_HI   4'h5

`endif

// *** common/dcc_pkg.sv ***
// Purpose: Types shared by the delay config block
// Assumes: Nothing beyond the params header
// Notes:   Formats follow the control register low bits
package dcc_pkg;

  // Stream format codes
  typedef enum logic [1:0] {
    DCC_FMT_I2S    = 2'h0,
    DCC_FMT_RJ     = 2'h1,
    DCC_FMT_LJ     = 2'h2,
    DCC_FMT_BYPASS = 2'h3
  } dcc_fmt_t;

  // Serial slave states
  typedef enum {
    DCC_ST_IDLE,
    DCC_ST_ADDR,
    DCC_ST_ACK_ADDR,
    DCC_ST_PTR,
    DCC_ST_ACK_PTR,
    DCC_ST_WDATA,
    DCC_ST_ACK_DATA,
    DCC_ST_RDATA,
    DCC_ST_RD_ACK
  } dcc_state_t;

endpackage : dcc_pkg

// *** hw/dcc_i2c_slave.sv ***
// Purpose: Two-wire serial slave with auto-incrementing register pointer
// Assumes: clk_sys far faster than the bus clock
// Notes:   Pins pass two flops; edges are seen from the second stage on
`timescale 1ns/1ps
`include "dcc_params.svh"

module dcc_i2c_slave
  import dcc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Address straps
  input  wire logic [2:0] addr_sel,
  // Register port
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;
  logic [2:0] add_sync1;
  logic [2:0] add_sync2;
  dcc_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic       nack;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, straps included since they may move at power-up
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      scl_d     <= 1'b1;
      sda_d     <= 1'b1;
      add_sync1 <= 3'h0;
      add_sync2 <= 3'h0;
    end else begin
      scl_sync  <= {scl_sync[0], scl_in};
      sda_sync  <= {sda_sync[0], sda_in};
      scl_d     <= scl_sync[1];
      sda_d     <= sda_sync[1];
      add_sync1 <= addr_sel;
      add_sync2 <= add_sync1;
    end
  end

  // Edge and condition detect on synchronised levels only
  assign scl_rise = scl_sync[1] & ~scl_d;
  assign scl_fall = ~scl_sync[1] & scl_d;
  assign start_c  = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_c   = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine; data changes on the falling clock, sampled on rising
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state   <= DCC_ST_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      tx      <= 8'h00;
      ptr     <= 8'h00;
      nack    <= 1'b1;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start_c) begin
        state   <= DCC_ST_ADDR;
        bit_cnt <= 4'h0;
      end else if (stop_c) begin
        state <= DCC_ST_IDLE;
      end else if (scl_rise) begin
        case (state)
          DCC_ST_ADDR, DCC_ST_PTR, DCC_ST_WDATA: begin
            shreg   <= {shreg[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          DCC_ST_RD_ACK: nack <= sda_sync[1];
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          DCC_ST_ADDR: begin
            if (bit_cnt == 4'h8) begin
              if (shreg[7:1] == {`DCC_BUS_ADDR_HI, add_sync2})
                state <= DCC_ST_ACK_ADDR;
              else
                state <= DCC_ST_IDLE;
            end
          end
          DCC_ST_ACK_ADDR: begin
            bit_cnt <= 4'h0;
            if (shreg[0]) begin
              tx    <= rd_data;
              state <= DCC_ST_RDATA;
            end else begin
              state <= DCC_ST_PTR;
            end
          end
          DCC_ST_PTR: begin
            if (bit_cnt == 4'h8) begin
              ptr   <= shreg;
              state <= DCC_ST_ACK_PTR;
            end
          end
          DCC_ST_ACK_PTR, DCC_ST_ACK_DATA: begin
            bit_cnt <= 4'h0;
            state   <= DCC_ST_WDATA;
          end
          DCC_ST_WDATA: begin
            if (bit_cnt == 4'h8) begin
              wr_en   <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr     <= ptr + 8'h01;
              state   <= DCC_ST_ACK_DATA;
            end
          end
          DCC_ST_RDATA: begin
            if (bit_cnt == 4'h7) begin
              ptr   <= ptr + 8'h01;
              state <= DCC_ST_RD_ACK;
            end else begin
              tx      <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          DCC_ST_RD_ACK: begin
            bit_cnt <= 4'h0;
            if (nack) begin
              state <= DCC_ST_IDLE;
            end else begin
              tx    <= rd_data;
              state <= DCC_ST_RDATA;
            end
          end
          default: state <= DCC_ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain drive: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = (state == DCC_ST_ACK_ADDR) | (state == DCC_ST_ACK_PTR) |
                   (state == DCC_ST_ACK_DATA) |
                   ((state == DCC_ST_RDATA) & ~tx[7]);
  assign rd_addr = ptr;

endmodule : dcc_i2c_slave

// *** hw/dcc_top.sv ***
// Purpose: Register file and commit logic of a stereo lip-sync delay
// Assumes: sample_tick is a one-cycle strobe per delayed sample, on clk_sys
// Notes:   Delay engine only sees new settings on a commit
//
// Notes on behaviour
// - Commit register bit 0 written zero transfers nothing; upper bits ignored.
// - Writing one copies format, delays and packet width to engine together.
// - New delays stay inactive; old delay stays in use until commit.
// - Mute bits in control register act at once, no commit needed.
// - Frame delay mode ignores per-channel sample delay registers.
// - Sequential reads return registers 0x01 to 0x08, pointer advancing.
// - Control bits 7/6 mute right/left; bits 1:0 select stream format.
// - After commit each channel stays muted until its delay passed.
`timescale 1ns/1ps
`include "dcc_params.svh"

module dcc_top
  import dcc_pkg::*;
#(
  parameter int DLY_W = 13
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Serial bus pins
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  input  wire logic [2:0]       addr_sel,
  // Delay engine side
  input  wire logic             sample_tick,
  output dcc_fmt_t              eng_format,
  output logic [DLY_W-1:0]      eng_delay_r,
  output logic [DLY_W-1:0]      eng_delay_l,
  output logic [5:0]            eng_pkt_len,
  output logic                  eng_load,
  output logic                  mute_r,
  output logic                  mute_l
);

  logic             wr_en;
  logic [7:0]       wr_addr;
  logic [7:0]       wr_data;
  logic [7:0]       rd_addr;
  logic [7:0]       rd_data;
  logic [7:0]       ctrl;
  logic [7:0]       dly_r_hi;
  logic [7:0]       dly_r_lo;
  logic [7:0]       dly_l_hi;
  logic [7:0]       dly_l_lo;
  logic [7:0]       frame;
  logic [7:0]       pkt_len;
  logic [7:0]       commit_reg;
  logic             commit;
  logic [DLY_W-1:0] frame_dly;
  logic [DLY_W-1:0] next_dly_r;
  logic [DLY_W-1:0] next_dly_l;
  logic [DLY_W-1:0] hold_r;
  logic [DLY_W-1:0] hold_l;

  // Frames to samples: int[(frames + 1) / rate * fs], limited to the engine maximum
  function automatic logic [DLY_W-1:0] dcc_frame_samples(
    input logic       rate_5994,
    input logic [2:0] fs_sel,
    input logic [2:0] frames
  );
    logic [39:0] fs_hz;
    logic [39:0] prod;
    logic [39:0] smp;
    fs_hz = 40'd0;
    prod  = 40'd0;
    smp   = 40'd0;
    case (fs_sel)
      3'h0:    fs_hz = 40'd32000;
      3'h1:    fs_hz = 40'd44100;
      3'h2:    fs_hz = 40'd48000;
      3'h3:    fs_hz = 40'd88200;
      3'h4:    fs_hz = 40'd96000;
      3'h5:    fs_hz = 40'd176400;
      default: fs_hz = 40'd192000;
    endcase
    prod = fs_hz * ({37'd0, frames} + 40'd1);
    // 59.94 Hz is 60000/1001, kept exact to avoid rounding drift
    if (rate_5994)
      smp = (prod * 40'd1001) / 40'd60000;
    else
      smp = prod / 40'd50;
    if (smp > {27'd0, `DCC_MAX_DELAY})
      return `DCC_MAX_DELAY;
    return smp[DLY_W-1:0];
  endfunction : dcc_frame_samples

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave
  dcc_i2c_slave u_slave (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .addr_sel (addr_sel),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file; writes only store, never reach the engine directly
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl       <= `DCC_RST_REG;
      dly_r_hi   <= `DCC_RST_REG;
      dly_r_lo   <= `DCC_RST_REG;
      dly_l_hi   <= `DCC_RST_REG;
      dly_l_lo   <= `DCC_RST_REG;
      frame      <= `DCC_RST_REG;
      pkt_len    <= `DCC_RST_REG;
      commit_reg <= `DCC_RST_REG;
    end else if (wr_en) begin
      case (wr_addr)
        `DCC_OFS_CTRL:     ctrl       <= wr_data;
        `DCC_OFS_DLY_R_HI: dly_r_hi   <= wr_data;
        `DCC_OFS_DLY_R_LO: dly_r_lo   <= wr_data;
        `DCC_OFS_DLY_L_HI: dly_l_hi   <= wr_data;
        `DCC_OFS_DLY_L_LO: dly_l_lo   <= wr_data;
        `DCC_OFS_FRAME:    frame      <= wr_data;
        `DCC_OFS_PKT_LEN:  pkt_len    <= wr_data;
        `DCC_OFS_COMMIT:   commit_reg <= wr_data;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (rd_addr)
      `DCC_OFS_CTRL:     rd_data = ctrl;
      `DCC_OFS_DLY_R_HI: rd_data = dly_r_hi;
      `DCC_OFS_DLY_R_LO: rd_data = dly_r_lo;
      `DCC_OFS_DLY_L_HI: rd_data = dly_l_hi;
      `DCC_OFS_DLY_L_LO: rd_data = dly_l_lo;
      `DCC_OFS_FRAME:    rd_data = frame;
      `DCC_OFS_PKT_LEN:  rd_data = pkt_len;
      `DCC_OFS_COMMIT:   rd_data = commit_reg;
      default:           rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // only bit 0 commits
  assign commit = wr_en & (wr_addr == `DCC_OFS_COMMIT) &
                  wr_data[`DCC_COMMIT_GO];

  assign frame_dly = dcc_frame_samples(frame[`DCC_FRAME_RATE],
                                       frame[5:3], frame[2:0]);

  always_comb begin
    if (frame[`DCC_FRAME_EN]) begin
      next_dly_r = frame_dly;
      next_dly_l = frame_dly;
    end else begin
      next_dly_r = {dly_r_hi[DLY_W-9:0], dly_r_lo};
      next_dly_l = {dly_l_hi[DLY_W-9:0], dly_l_lo};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      eng_format  <= DCC_FMT_I2S;
      eng_delay_r <= '0;
      eng_delay_l <= '0;
      eng_pkt_len <= 6'h00;
      eng_load    <= 1'b0;
    end else begin
      eng_load <= commit;
      if (commit) begin
        eng_format  <= dcc_fmt_t'(ctrl[1:0]);
        eng_delay_r <= next_dly_r;
        eng_delay_l <= next_dly_l;
        // Packet width bits 5:0 over the maximum are limited, not wrapped; bits 7:6 are dropped
        if (pkt_len[5:0] > `DCC_MAX_PKT_LEN)
          eng_pkt_len <= `DCC_MAX_PKT_LEN;
        else
          eng_pkt_len <= pkt_len[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // post-commit mute hold; counts samples out of the engine
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hold_r <= '0;
      hold_l <= '0;
    end else if (commit) begin
      hold_r <= next_dly_r;
      hold_l <= next_dly_l;
    end else if (sample_tick) begin
      if (hold_r != '0)
        hold_r <= hold_r - {{(DLY_W-1){1'b0}}, 1'b1};
      if (hold_l != '0)
        hold_l <= hold_l - {{(DLY_W-1){1'b0}}, 1'b1};
    end
  end

  // bit 7 right, bit 6 left
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mute_r <= 1'b0;
      mute_l <= 1'b0;
    end else begin
      mute_r <= ctrl[`DCC_CTRL_MUTE_R] | (hold_r != '0);
      mute_l <= ctrl[`DCC_CTRL_MUTE_L] | (hold_l != '0);
    end
  end

endmodule : dcc_top

// *** tb/dcc_top_monitor.sv ***
// Purpose: Port assertions for the delay config block
// Assumes: One clock, reset_n async active low
// Notes:   Bound into every dcc_top
`timescale 1ns/1ps
module dcc_top_monitor
  import dcc_pkg::*;
#(
  parameter int DLY_W = 13
)
(
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             reset_n,
  // Bus
  input wire logic             scl_in,
  input wire logic             sda_oe,
  // Engine side
  input dcc_fmt_t              eng_format,
  input wire logic [DLY_W-1:0] eng_delay_r,
  input wire logic [DLY_W-1:0] eng_delay_l,
  input wire logic [5:0]       eng_pkt_len,
  input wire logic             eng_load,
  input wire logic             mute_r,
  input wire logic             mute_l
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////
  // Engine delays and format move only with the load pulse; width clamped, load one cycle
  a_delay_r_held: assert property ($changed(eng_delay_r) |-> eng_load)
    else $error("right delay moved without load");
  a_delay_l_held: assert property ($changed(eng_delay_l) |-> eng_load)
    else $error("left delay moved without load");
  a_format_held: assert property ($changed(eng_format) |-> eng_load)
    else $error("format moved without load");
  a_pkt_clamped: assert property (eng_pkt_len <= 6'h18)
    else $error("packet width above 24");
  a_load_single: assert property (eng_load |=> !eng_load)
    else $error("load longer than one cycle");
  // Commit lands while the bus clock is low after the 8th bit
  a_load_scl_low: assert property (eng_load |-> !scl_in)
    else $error("load outside a commit write");
  // Both mutes up the cycle after a load of delays above 2
  a_mute_after_load: assert property (eng_load && eng_delay_r > 2 &&
    eng_delay_l > 2 |=> mute_r && mute_l)
    else $error("no mute hold after load");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data pin moved with clock high");

  cover property (eng_load);
  cover property ($fell(mute_l));
  cover property ($rose(sda_oe));
endmodule : dcc_top_monitor

bind dcc_top dcc_top_monitor #(.DLY_W(DLY_W)) dcc_top_monitor_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl_in),
  .sda_oe(sda_oe), .eng_format(eng_format), .eng_delay_r(eng_delay_r),
  .eng_delay_l(eng_delay_l), .eng_pkt_len(eng_pkt_len),
  .eng_load(eng_load), .mute_r(mute_r), .mute_l(mute_l)
);

// *** tb/dcc_i2c_master.sv ***
// Purpose: Two-wire bus master model on the block's serial pins
// Assumes: Pull-up on the data line
// Notes:   Pins move 1 ns after a clk_sys rising edge
`timescale 1ns/1ps
module dcc_i2c_master #(
  parameter int HALF = 8
)
(
  // Pacing clock
  input  wire logic clk_sys,
  // Bus wires
  output logic      scl,
  output logic      sda,
  input  wire logic dut_oe
);
  logic drv_low;

  ////////////////////////////////////////
  // Open-drain wire: released means pulled high
  assign sda = !(drv_low || dut_oe);

  // Idle bus, clock stands high
  initial begin
    scl = 1'b1;
    drv_low = 1'b0;
  end

  task automatic half;
    repeat (HALF) @(posedge clk_sys);
    #1;
  endtask : half

  // Start or repeated start
  task automatic start;
    drv_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    drv_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask : start

  task automatic stop;
    drv_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    drv_low = 1'b0;
    half();
  endtask : stop

  // Nine bits; data held through the high phase
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      drv_low = !d[i];
      half();
      scl = 1'b1;
      half();
      q[i] = sda;
      scl = 1'b0;
      half();
    end
  endtask : xbyte
endmodule : dcc_i2c_master

// *** tb/tb_dcc_top.sv ***
// Purpose: Self-checking bench for the delay config block
// Assumes: Bus master model on the pins, bench pulses sample_tick
// Notes:   Expected register contents kept in a shadow copy
`timescale 1ns/1ps
`include "dcc_params.svh"
module tb_dcc_top
  import dcc_pkg::*;
;
  logic clk_sys, reset_n, sample_tick, sda_out, sda_oe;
  logic eng_load, mute_r, mute_l;
  logic [2:0] addr_sel;
  wire scl_in, sda_in;
  dcc_fmt_t eng_format;
  logic [12:0] eng_delay_r, eng_delay_l;
  logic [5:0] eng_pkt_len;
  logic [7:0] shadow [0:255];
  // Frame codes cover every sample rate and both frame rates
  logic [7:0] frm [8] = '{8'h91, 8'hd0, 8'hb7, 8'h88, 8'h99, 8'he0,
                          8'haa, 8'h83};
  logic [12:0] dly [8] = '{13'h780, 13'h320, 13'h1fff, 13'h372, 13'hdc8,
                           13'h641, 13'h1fff, 13'ha00};
  int miscompares = 0;
  int n_compared = 0;
  int n_load = 0;

  dcc_top #(.DLY_W(13)) dcc_top_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .sample_tick(sample_tick),
    .eng_format(eng_format), .eng_delay_r(eng_delay_r),
    .eng_delay_l(eng_delay_l), .eng_pkt_len(eng_pkt_len),
    .eng_load(eng_load), .mute_r(mute_r), .mute_l(mute_l));
  dcc_i2c_master dcc_i2c_master_i (.clk_sys(clk_sys), .scl(scl_in),
    .sda(sda_in), .dut_oe(sda_oe));

  ////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Count load pulses seen by the engine
  always @(posedge clk_sys) begin
    if (eng_load === 1'b1) n_load++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic adr(input logic rnw);
    logic [8:0] q;
    dcc_i2c_master_i.xbyte({`DCC_BUS_ADDR_HI, addr_sel, rnw, 1'b1}, q);
    check(q[0], 1'b0);
  endtask : adr

  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic [8:0] q;
    dcc_i2c_master_i.start();
    adr(1'b0);
    dcc_i2c_master_i.xbyte({p, 1'b1}, q);
    check(q[0], 1'b0);
    // a byte for every place in the burst
    foreach (d[i]) begin
      dcc_i2c_master_i.xbyte({d[i], 1'b1}, q);
      check(q[0], 1'b0);
      if (p >= 8'h01 && p <= 8'h08) shadow[p] = d[i];
      p++;
    end
    dcc_i2c_master_i.stop();
  endtask : wr

  task automatic rd(input logic [7:0] p, input int n);
    logic [8:0] q;
    dcc_i2c_master_i.start();
    adr(1'b0);
    dcc_i2c_master_i.xbyte({p, 1'b1}, q);
    dcc_i2c_master_i.start();
    adr(1'b1);
    for (int i = 0; i < n; i++) begin
      // last byte refused by the master
      dcc_i2c_master_i.xbyte({8'hff, i == n - 1}, q);
      check(q[8:1], shadow[p]);
      p++;
    end
    dcc_i2c_master_i.stop();
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      sample_tick = 1'b1;
      @(posedge clk_sys);
      #1;
      sample_tick = 1'b0;
      @(posedge clk_sys);
      #1;
    end
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : ticks

  task automatic wrap_up;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    reset_n = 1'b0;
    addr_sel = 3'h1;
    sample_tick = 1'b0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (4) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    check({eng_format, mute_r, mute_l}, 4'h0);
    check({sda_out, sda_oe}, 2'h0);
    rd(8'h01, 8);
    wr(8'h01, '{8'h00, 8'h0f, 8'hff, 8'h10, 8'h00});
    rd(8'h01, 8);
    check(eng_delay_r, 13'h0);
    wr(8'h08, '{8'hfe});
    check(n_load[15:0], 16'h0);
    check(eng_delay_r, 13'h0);
    wr(8'h08, '{8'h01});
    check(n_load[15:0], 16'h1);
    check(eng_delay_r, 13'hfff);
    check(eng_delay_l, 13'h1000);
    check({mute_r, mute_l}, 2'h3);
    ticks(4095);
    check({mute_r, mute_l}, 2'h1);
    ticks(1);
    check({mute_r, mute_l}, 2'h0);
    wr(8'h01, '{8'hc1});
    check({mute_r, mute_l, eng_format}, 4'hc);
    wr(8'h01, '{8'h80});
    check({mute_r, mute_l}, 2'h2);
    wr(8'h01, '{8'h40});
    check({mute_r, mute_l}, 2'h1);
    // Each format with an over-long packet width
    for (int f = 0; f < 4; f++) begin
      wr(8'h01, '{f[7:0], 8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h1f,
        8'h01});
      check(eng_format, f[15:0]);
      check(eng_pkt_len, `DCC_MAX_PKT_LEN);
      check(eng_delay_r, 13'h2);
      check(eng_delay_l, 13'h3);
    end
    // Frame delay masks the per-channel values
    foreach (frm[i]) begin
      wr(8'h02, '{8'h0f, 8'hff, 8'h0f, 8'hff, frm[i], 8'h10, 8'h01});
      check(eng_delay_r, dly[i]);
      check(eng_delay_l, dly[i]);
      check(eng_pkt_len, 6'h10);
    end
    wr(8'h00, '{8'haa});
    rd(8'h00, 9);
    wrap_up();
  end

  // Watchdog, well past the ~50k cycles needed
  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end
endmodule : tb_dcc_top
